/* design/debug_cmd_pkg.sv */
// constants shared by the background debug command unit and its helpers
// assumes a single 10 MHz core clock and a synchronous serial strobe
package debug_cmd_pkg;
  // ********************************
  // serial frame layout
  // ********************************
  localparam int FRAME_W  = 32;
  localparam int CMD_MSB  = 15;
  localparam int CMD_LSB  = 12;
  localparam int SYS_BIT  = 8;
  localparam int SIZE_MSB = 5;
  localparam int SIZE_LSB = 4;
  localparam int SEL_MSB  = 3;
  localparam int SEL_LSB  = 0;
  // ********************************
  // command codes
  // ********************************
  localparam logic [3:0] CMD_NULL  = 4'h0;
  localparam logic [3:0] CMD_RDGEN = 4'h1;
  localparam logic [3:0] CMD_WRGEN = 4'h2;
  localparam logic [3:0] CMD_RDSYS = 4'h3;
  localparam logic [3:0] CMD_WRSYS = 4'h4;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h6;
  localparam logic [3:0] CMD_DUMP  = 4'h7;
  localparam logic [3:0] CMD_FILL  = 4'h8;
  localparam logic [3:0] CMD_GO    = 4'h9;
  localparam logic [3:0] CMD_CALL  = 4'ha;
  localparam logic [3:0] CMD_RST   = 4'hb;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  // ********************************
  // exception vectors and opcodes
  // ********************************
  localparam logic [7:0]  VEC_ILLEGAL = 8'h04;
  localparam logic [7:0]  VEC_TRACE   = 8'h09;
  localparam logic [7:0]  VEC_LINE_A  = 8'h0a;
  localparam logic [7:0]  VEC_LINE_F  = 8'h0b;
  localparam logic [7:0]  VEC_BKPT    = 8'h0c;
  localparam logic [15:0] BKPT_LO     = 16'h4848;
  localparam logic [15:0] BKPT_HI     = 16'h484f;
  localparam logic [3:0]  LINE_A      = 4'ha;
  localparam logic [3:0]  LINE_F      = 4'hf;
  localparam logic [1:0]  TRACE_ALL   = 2'h2;
  localparam logic [1:0]  TRACE_FLOW  = 2'h1;
  localparam logic [2:0]  FC_SUP_DATA = 3'h5;
  localparam logic [31:0] STACK_STEP  = 32'h0000_0004;
  // ********************************
  // timing
  // ********************************
  localparam int RST_CYCLES = 512;
endpackage : debug_cmd_pkg

/* design/debug_shifter.sv */
// full duplex serial shifter for debug frames, msb first
// assumes shift_i is a one-cycle strobe synchronous to clock_i
`timescale 1ns/1ps
module debug_shifter
  import debug_cmd_pkg::*;
#(
  parameter int W = FRAME_W
) (
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  input  wire logic         shift_i,
  input  wire logic         sdata_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_data_i,
  output logic              sdata_o,
  output logic              word_valid_o,
  output logic [W-1:0]      word_o
);
  logic [W-1:0]         in_q;
  logic [W-1:0]         out_q;
  logic [$clog2(W)-1:0] cnt_q;
  logic                 last;

  assign last    = shift_i && (cnt_q == ($clog2(W))'(W - 1));
  assign sdata_o = out_q[W-1];
  assign word_o  = in_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_q  <= '0;
      cnt_q <= '0;
    end else if (shift_i) begin
      in_q  <= {in_q[W-2:0], sdata_i};
      cnt_q <= last ? '0 : cnt_q + 1'b1;
    end
  end

  // result goes out while the next frame comes in
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_q <= '0;
    end else if (load_i) begin
      out_q <= load_data_i;
    end else if (shift_i) begin
      out_q <= {out_q[W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_valid_o <= 1'b0;
    end else begin
      word_valid_o <= last;
    end
  end
endmodule : debug_shifter

/* design/periph_reset_pulse.sv */
// fixed length reset pulse for the peripherals, core untouched
// assumes start_i is a one-cycle pulse
`timescale 1ns/1ps
module periph_reset_pulse
  import debug_cmd_pkg::*;
#(
  parameter int CYCLES = RST_CYCLES
) (
  input  wire logic clock_i,
  input  wire logic resetn_i,
  input  wire logic start_i,
  output logic      reset_o
);
  logic [$clog2(CYCLES+1)-1:0] cnt_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (start_i && cnt_q == '0) begin
      cnt_q <= ($clog2(CYCLES+1))'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reset_o <= 1'b0;
    end else begin
      reset_o <= (cnt_q > 1) || (start_i && cnt_q == '0);
    end
  end

  AST_RST_WIDTH: assert property (@(posedge clock_i)
    disable iff (!resetn_i) $rose(reset_o) |-> reset_o [*8])
    else $error("peripheral reset shorter than expected");
endmodule : periph_reset_pulse

/* design/debug_cmd_unit.sv */
// background debug command unit: serial command decode and dispatch,
// register and memory access, resume, patch, peripheral reset, and
// trace, breakpoint and unimplemented opcode trapping
// assumes core register and memory ports answer as described at ports
`timescale 1ns/1ps
module debug_cmd_unit
  import debug_cmd_pkg::*;
#(
  parameter int W = FRAME_W
) (
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  input  wire logic         dbg_clk_i,
  input  wire logic         dbg_in_i,
  output logic              dbg_out_o,
  output logic              background_debug_mode_o,
  output logic              reg_rd_o,
  output logic              reg_wr_o,
  output logic              reg_sys_o,
  output logic [3:0]        reg_sel_o,
  output logic [W-1:0]      reg_wdata_o,
  input  wire logic [W-1:0] reg_rdata_i,
  input  wire logic [2:0]   source_space_code_reg_i,
  input  wire logic [2:0]   destination_space_code_reg_i,
  input  wire logic [W-1:0] pc_i,
  input  wire logic [W-1:0] stack_ptr_i,
  output logic              mem_req_o,
  output logic              mem_we_o,
  output logic [W-1:0]      mem_addr_o,
  output logic [1:0]        mem_size_o,
  output logic [2:0]        mem_fc_o,
  output logic [W-1:0]      mem_wdata_o,
  input  wire logic [W-1:0] mem_rdata_i,
  input  wire logic         mem_ack_i,
  output logic              pipe_flush_o,
  output logic              pc_load_o,
  output logic [W-1:0]      pc_value_o,
  output logic              sp_push_o,
  output logic              periph_reset_o,
  input  wire logic         instr_done_i,
  input  wire logic [15:0]  opcode_i,
  input  wire logic         illegal_i,
  input  wire logic         flow_change_i,
  input  wire logic [1:0]   trace_mode_i,
  input  wire logic         bkpt_ack_i,
  input  wire logic         bkpt_to_debug_i,
  output logic              exc_req_o,
  output logic [7:0]        exc_vector_o
);
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DATA, ST_REG, ST_MEM
  } state_e;

  state_e         state_q;
  logic [3:0]     op_q;
  logic           we_q;
  logic [W-1:0]   addr_q;
  logic [W-1:0]   data_q;
  logic [W-1:0]   target_q;
  logic           word_valid;
  logic [W-1:0]   word;
  logic [3:0]     op_d;
  logic           load;
  logic [W-1:0]   load_data;
  logic           rst_start;
  logic           bkpt_op;
  logic           go_now;
  logic           call_done;
  logic           enter_dbg;
  logic [W-1:0]   step;

  // ********************************
  // serial link
  // ********************************
  debug_shifter #(.W(W)) debug_shifter_inst (
    .clock_i      (clock_i),
    .resetn_i     (resetn_i),
    .shift_i      (dbg_clk_i),
    .sdata_i      (dbg_in_i),
    .load_i       (load),
    .load_data_i  (load_data),
    .sdata_o      (dbg_out_o),
    .word_valid_o (word_valid),
    .word_o       (word)
  );

  periph_reset_pulse periph_reset_pulse_inst (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .start_i  (rst_start),
    .reset_o  (periph_reset_o)
  );

  // ********************************
  // command dispatch
  // ********************************
  // routine selected straight from the command field
  assign op_d = word[CMD_MSB:CMD_LSB];
  assign rst_start = word_valid && state_q == ST_CMD &&
                     background_debug_mode_o && op_d == CMD_RST;
  assign go_now = word_valid && state_q == ST_CMD &&
                  background_debug_mode_o && op_d == CMD_GO;
  assign call_done = state_q == ST_MEM && mem_ack_i && op_q == CMD_CALL;
  assign load = (state_q == ST_REG && !we_q) ||
                (state_q == ST_MEM && mem_ack_i && !we_q);
  assign load_data = (state_q == ST_REG) ? reg_rdata_i : mem_rdata_i;
  assign reg_rd_o = state_q == ST_REG && !we_q;
  assign reg_wr_o = state_q == ST_REG && we_q;
  assign mem_req_o = state_q == ST_MEM;
  assign mem_addr_o = addr_q;
  assign mem_wdata_o = data_q;
  assign reg_wdata_o = data_q;
  assign mem_we_o = we_q;
  assign pc_value_o = target_q;

  // a dump steps by the size in its own command word
  always_comb begin
    unique case ((state_q == ST_CMD) ? word[SIZE_MSB:SIZE_LSB] :
                 mem_size_o)
      SIZE_BYTE: step = W'(1);
      SIZE_WORD: step = W'(2);
      default:   step = W'(4);
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_CMD;
      op_q    <= CMD_NULL;
      we_q    <= 1'b0;
    end else begin
      unique case (state_q)
        ST_CMD: if (word_valid && background_debug_mode_o) begin
          op_q <= op_d;
          unique case (op_d)
            CMD_RDGEN, CMD_RDSYS: begin
              we_q    <= 1'b0;
              state_q <= ST_REG;
            end
            CMD_WRGEN, CMD_WRSYS, CMD_FILL, CMD_CALL: begin
              we_q    <= op_d != CMD_CALL ? op_d != CMD_FILL : 1'b1;
              state_q <= ST_DATA;
            end
            CMD_READ, CMD_WRITE: begin
              state_q <= ST_ADDR;
            end
            CMD_DUMP: begin
              we_q    <= 1'b0;
              state_q <= ST_MEM;
            end
            default: state_q <= ST_CMD;
          endcase
        end
        ST_ADDR: if (word_valid) begin
          we_q    <= op_q == CMD_WRITE;
          state_q <= op_q == CMD_WRITE ? ST_DATA : ST_MEM;
        end
        ST_DATA: if (word_valid) begin
          we_q    <= op_q == CMD_WRGEN || op_q == CMD_WRSYS ||
                     op_q == CMD_WRITE || op_q == CMD_FILL ||
                     op_q == CMD_CALL;
          state_q <= (op_q == CMD_WRGEN || op_q == CMD_WRSYS) ?
                     ST_REG : ST_MEM;
        end
        ST_REG: state_q <= ST_CMD;
        ST_MEM: if (mem_ack_i) begin
          state_q <= ST_CMD;
        end
        default: state_q <= ST_CMD;
      endcase
    end
  end

  // register selection latched with the command
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_sel_o  <= '0;
      reg_sys_o  <= 1'b0;
      mem_size_o <= SIZE_LONG;
    end else if (word_valid && state_q == ST_CMD &&
                 background_debug_mode_o && op_d != CMD_NULL) begin
      reg_sel_o  <= word[SEL_MSB:SEL_LSB];
      reg_sys_o  <= word[SYS_BIT];
      mem_size_o <= op_d == CMD_CALL ? SIZE_LONG :
                    word[SIZE_MSB:SIZE_LSB];
    end
  end

  // address, operand and space code
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_q   <= '0;
      data_q   <= '0;
      target_q <= '0;
      mem_fc_o <= FC_SUP_DATA;
    end else if (state_q == ST_ADDR && word_valid) begin
      addr_q   <= word;
      mem_fc_o <= op_q == CMD_WRITE ? destination_space_code_reg_i
                : source_space_code_reg_i;
    end else if (state_q == ST_CMD && word_valid &&
                 background_debug_mode_o && op_d == CMD_DUMP) begin
      addr_q   <= addr_q + step;
      mem_fc_o <= source_space_code_reg_i;
    end else if (state_q == ST_DATA && word_valid) begin
      if (op_q == CMD_CALL) begin
        target_q <= word;
        data_q   <= pc_i;
        addr_q   <= stack_ptr_i - STACK_STEP;
        mem_fc_o <= FC_SUP_DATA;
      end else begin
        data_q <= word;
        if (op_q == CMD_FILL) begin
          addr_q   <= addr_q + step;
          mem_fc_o <= destination_space_code_reg_i;
        end
      end
    end
  end

  // ********************************
  // execution control
  // ********************************
  assign bkpt_op = illegal_i && opcode_i >= BKPT_LO &&
                   opcode_i <= BKPT_HI;
  assign enter_dbg = !background_debug_mode_o && bkpt_to_debug_i &&
                     (bkpt_ack_i || (instr_done_i && bkpt_op));

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      background_debug_mode_o <= 1'b0;
    end else if (enter_dbg) begin
      background_debug_mode_o <= 1'b1;
    end else if (go_now || call_done) begin
      background_debug_mode_o <= 1'b0;
    end
  end

  // pipe refill on both ways out; pc load only for patch code
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pipe_flush_o <= 1'b0;
      pc_load_o    <= 1'b0;
      sp_push_o    <= 1'b0;
    end else begin
      pipe_flush_o <= go_now || call_done;
      pc_load_o    <= call_done;
      sp_push_o    <= call_done;
    end
  end

  // trapping only while running; debug mode masks everything
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      exc_req_o    <= 1'b0;
      exc_vector_o <= '0;
    end else begin
      exc_req_o <= 1'b0;
      if (!background_debug_mode_o && !bkpt_to_debug_i &&
          (bkpt_ack_i || (instr_done_i && bkpt_op))) begin
        exc_req_o    <= 1'b1;
        exc_vector_o <= VEC_BKPT;
      end else if (!background_debug_mode_o && instr_done_i) begin
        exc_req_o <= 1'b1;
        if (opcode_i[15:12] == LINE_A) begin
          exc_vector_o <= VEC_LINE_A;
        end else if (opcode_i[15:12] == LINE_F) begin
          exc_vector_o <= VEC_LINE_F;
        end else if (illegal_i) begin
          exc_vector_o <= VEC_ILLEGAL;
        end else if (trace_mode_i == TRACE_ALL ||
                     (trace_mode_i == TRACE_FLOW && flow_change_i)) begin
          exc_vector_o <= VEC_TRACE;
        end else begin
          exc_req_o <= 1'b0;
        end
      end
    end
  end

  // ********************************
  // checks
  // ********************************
  default disable iff (!resetn_i);

  AST_REG_READ: assert property (@(posedge clock_i)
    reg_rd_o |=> state_q == ST_CMD)
    else $error("register read not single cycle");
  AST_NULL_IDLE: assert property (@(posedge clock_i)
    (state_q == ST_CMD && word_valid && op_d == CMD_NULL)
    |=> state_q == ST_CMD && !mem_req_o && !reg_wr_o)
    else $error("null command caused activity");
  AST_WAIT_WORD: assert property (@(posedge clock_i)
    (state_q == ST_DATA && !word_valid) |=> $stable(data_q))
    else $error("operand changed before word arrived");
  AST_HALT: assert property (@(posedge clock_i)
    (background_debug_mode_o && !go_now && !call_done)
    |=> background_debug_mode_o)
    else $error("left debug mode without resume or patch");
  AST_GO_FLUSH: assert property (@(posedge clock_i)
    go_now |=> pipe_flush_o && !background_debug_mode_o)
    else $error("resume did not flush");
  AST_CALL_PC: assert property (@(posedge clock_i)
    call_done |-> mem_we_o ##1 pc_load_o && pipe_flush_o)
    else $error("patch did not load pc");
  AST_BKPT_VEC: assert property (@(posedge clock_i)
    (instr_done_i && bkpt_op && !bkpt_to_debug_i &&
     !background_debug_mode_o) |=> exc_req_o && exc_vector_o == VEC_BKPT)
    else $error("breakpoint opcode not trapped");
  AST_LINE_A: assert property (@(posedge clock_i)
    (instr_done_i && opcode_i[15:12] == LINE_A && !bkpt_ack_i &&
     !background_debug_mode_o) |=> exc_vector_o == VEC_LINE_A)
    else $error("line a vector wrong");
  AST_RESULT: assert property (@(posedge clock_i)
    (state_q == ST_MEM && mem_ack_i && !we_q) |-> load)
    else $error("read result not loaded");
  AST_RST_GO: assert property (@(posedge clock_i)
    rst_start |-> ##2 periph_reset_o)
    else $error("peripheral reset not driven");

  COV_DUMP: cover property (@(posedge clock_i) disable iff (!resetn_i)
    state_q == ST_CMD && word_valid && op_d == CMD_DUMP);
  COV_FILL: cover property (@(posedge clock_i) disable iff (!resetn_i)
    state_q == ST_DATA && word_valid && op_q == CMD_FILL);
  COV_CALL: cover property (@(posedge clock_i) disable iff (!resetn_i)
    call_done);
  COV_TRACE: cover property (@(posedge clock_i) disable iff (!resetn_i)
    exc_req_o && exc_vector_o == VEC_TRACE);
endmodule : debug_cmd_unit

/* sim/debug_host_model.sv */
// debug host model: shifts 32-bit frames in and out over the strobe link
// assumes the unit samples the data line on strobe edges of clock_i
`timescale 1ns/1ps
module debug_host_model (
  input  wire logic clock_i,
  input  wire logic dbg_out_i,
  output logic      dbg_clk_o,
  output logic      dbg_in_o
);
  // ****************
  // frame transfer
  // ****************
  initial begin
    dbg_clk_o = 1'b0;
    dbg_in_o  = 1'b1;
  end

  // reply bit is taken before each strobe, while it stands
  task automatic send(input logic [31:0] f, output logic [31:0] r);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clock_i) #1;
      r[i]      = dbg_out_i;
      dbg_in_o  = f[i];
      dbg_clk_o = 1'b1;
      @(posedge clock_i) #1;
      dbg_clk_o = 1'b0;
    end
    // idle line inverted so a stale bit is never mistaken for data
    dbg_in_o = ~f[0];
    // gap lets the result load before the next frame starts
    repeat (12) @(posedge clock_i);
  endtask : send
endmodule : debug_host_model

/* sim/test_background_debug_command_unit.sv */
// self-checking bench for the background debug command unit
// assumes the host model drives the link and this bench the core side
`timescale 1ns/1ps
module test_background_debug_command_unit;
  import debug_cmd_pkg::*;
  // ****************
  // signals
  // ****************
  logic        clock_i, resetn_i, dbg_clk_i, dbg_in_i, dbg_out_o;
  logic        background_debug_mode_o, reg_rd_o, reg_wr_o, reg_sys_o;
  logic        mem_req_o, mem_we_o, mem_ack_i, pipe_flush_o, pc_load_o;
  logic        sp_push_o, periph_reset_o, instr_done_i, illegal_i;
  logic        flow_change_i, bkpt_ack_i, bkpt_to_debug_i, exc_req_o;
  logic [3:0]  reg_sel_o;
  logic [1:0]  mem_size_o, trace_mode_i;
  logic [2:0]  source_space_code_reg_i, destination_space_code_reg_i;
  logic [2:0]  mem_fc_o;
  logic [15:0] opcode_i;
  logic [7:0]  exc_vector_o;
  logic [31:0] reg_wdata_o, reg_rdata_i, pc_i, stack_ptr_i, mem_addr_o;
  logic [31:0] mem_wdata_o, mem_rdata_i, pc_value_o, r;
  logic [31:0] w_dat, a_adr, a_wd;
  logic [3:0]  w_sel;
  logic [2:0]  a_fc;
  logic [1:0]  a_sz;
  logic        w_sys, a_we;
  int          n_fail, total_checks, cyc, n_flush, n_pcl, n_push, n_prst;
  int          n_wr, n_mem, wq, b0, b1, b2;

  debug_cmd_unit debug_cmd_unit_inst (
    .clock_i, .resetn_i, .dbg_clk_i, .dbg_in_i, .dbg_out_o,
    .background_debug_mode_o, .reg_rd_o, .reg_wr_o, .reg_sys_o,
    .reg_sel_o, .reg_wdata_o, .reg_rdata_i, .source_space_code_reg_i,
    .destination_space_code_reg_i, .pc_i, .stack_ptr_i, .mem_req_o,
    .mem_we_o, .mem_addr_o, .mem_size_o, .mem_fc_o, .mem_wdata_o,
    .mem_rdata_i, .mem_ack_i, .pipe_flush_o, .pc_load_o, .pc_value_o,
    .sp_push_o, .periph_reset_o, .instr_done_i, .opcode_i, .illegal_i,
    .flow_change_i, .trace_mode_i, .bkpt_ack_i, .bkpt_to_debug_i,
    .exc_req_o, .exc_vector_o);

  debug_host_model debug_host_model_inst (.clock_i(clock_i),
    .dbg_out_i(dbg_out_o), .dbg_clk_o(dbg_clk_i), .dbg_in_o(dbg_in_i));

  // ****************
  // core side models
  // ****************
  function automatic logic [31:0] rv(input logic s, input logic [3:0] sl);
    return 32'h1234_5600 | {s, 23'h0, 4'h0, sl};
  endfunction : rv
  // register data only valid in the read cycle, garbage otherwise
  assign reg_rdata_i = reg_rd_o ? rv(reg_sys_o, reg_sel_o) : 32'hdead_beef;
  assign mem_rdata_i = mem_ack_i ? mem_addr_o ^ 32'h5555_0000 : ~mem_addr_o;

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 12000) begin
      n_fail++;
      test_done();
    end
  end

  // slow memory: ack two cycles after the request shows
  always @(posedge clock_i) begin
    n_flush += pipe_flush_o;
    n_pcl += pc_load_o;
    n_push += sp_push_o;
    n_prst += periph_reset_o;
    if (reg_wr_o === 1'b1) begin
      n_wr++;
      w_dat = reg_wdata_o;
      w_sel = reg_sel_o;
      w_sys = reg_sys_o;
    end
    if (mem_ack_i) begin
      n_mem++;
      a_adr = mem_addr_o;
      a_wd = mem_wdata_o;
      a_fc = mem_fc_o;
      a_sz = mem_size_o;
      a_we = mem_we_o;
    end
    #1;
    if (mem_ack_i) begin
      mem_ack_i = 1'b0;
      wq = 0;
    end else if (mem_req_o === 1'b1) begin
      wq++;
      mem_ack_i = (wq == 3);
    end
  end

  // ****************
  // helpers
  // ****************
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic test_done();
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic tx(input logic [31:0] f);
    debug_host_model_inst.send(f, r);
  endtask : tx

  function automatic logic [31:0] cw(input logic [3:0] c, input logic s,
                                     input logic [1:0] z, input logic [3:0] l);
    return {16'h0, c, 3'h0, s, 2'h0, z, l};
  endfunction : cw

  task automatic exc(input logic [15:0] o, input logic il, input logic fl,
                     input logic [1:0] tm, input logic bk,
                     input logic [7:0] ev);
    @(posedge clock_i) #1;
    opcode_i = o;
    illegal_i = il;
    flow_change_i = fl;
    trace_mode_i = tm;
    bkpt_ack_i = bk;
    instr_done_i = ~bk;
    @(posedge clock_i) #1;
    instr_done_i = 1'b0;
    bkpt_ack_i = 1'b0;
    chk("exc_req", exc_req_o, ev != 8'h00);
    if (ev != 8'h00)
      chk("exc_vector", exc_vector_o, ev);
  endtask : exc

  // ****************
  // scenarios
  // ****************
  task automatic t_exc();
    exc(16'h4e71, 0, 0, TRACE_ALL, 0, VEC_TRACE);
    exc(16'h4e71, 0, 0, TRACE_FLOW, 0, 8'h00);
    exc(16'h4e71, 0, 1, TRACE_FLOW, 0, VEC_TRACE);
    exc(16'h4848, 1, 0, 2'h0, 0, VEC_BKPT);
    exc(16'h484f, 1, 0, TRACE_ALL, 0, VEC_BKPT);
    exc(16'h4847, 1, 0, 2'h0, 0, VEC_ILLEGAL);
    exc(16'h4850, 1, 0, 2'h0, 0, VEC_ILLEGAL);
    exc(16'ha123, 1, 0, 2'h0, 0, VEC_LINE_A);
    exc(16'hf123, 1, 0, 2'h0, 0, VEC_LINE_F);
    exc(16'h4e71, 0, 0, 2'h0, 1, VEC_BKPT);
    bkpt_to_debug_i = 1'b1;
    exc(16'h4e71, 0, 0, 2'h0, 1, 8'h00);
    chk("dbg_mode", background_debug_mode_o, 1);
    exc(16'h4e71, 0, 0, TRACE_ALL, 0, 8'h00);
  endtask : t_exc

  task automatic t_regs();
    for (int s = 0; s < 2; s++) begin
      tx(cw(s ? CMD_RDSYS : CMD_RDGEN, s[0], SIZE_LONG, 4'h5 + s[3:0]));
      tx(cw(CMD_NULL, 0, 0, 0));
      chk("reg_read", r, rv(s[0], 4'h5 + s[3:0]));
      b0 = n_wr;
      tx(cw(s ? CMD_WRSYS : CMD_WRGEN, s[0], SIZE_LONG, 4'h3 + s[3:0]));
      chk("wr_wait", n_wr, b0);
      tx(32'hcafe_0001 + s);
      chk("wr_count", n_wr, b0 + 1);
      chk("wr_sel", w_sel, 4'h3 + s[3:0]);
      chk("wr_sys", w_sys, s[0]);
      chk("wr_data", w_dat, 32'hcafe_0001 + s);
    end
    b0 = n_wr;
    b1 = n_mem;
    tx(cw(CMD_NULL, 0, 0, 0));
    chk("null_wr", n_wr, b0);
    chk("null_mem", n_mem, b1);
    chk("null_dbg_mode", background_debug_mode_o, 1);
  endtask : t_regs

  task automatic t_mem();
    tx(cw(CMD_READ, 0, SIZE_LONG, 0));
    tx(32'h0000_1000);
    chk("rd_addr", a_adr, 32'h0000_1000);
    chk("rd_fc", a_fc, 3'h1);
    chk("rd_size", a_sz, SIZE_LONG);
    chk("rd_we", a_we, 0);
    tx(cw(CMD_DUMP, 0, SIZE_LONG, 0));
    chk("rd_data", r, 32'h5555_1000);
    chk("dump_addr", a_adr, 32'h0000_1004);
    tx(cw(CMD_NULL, 0, 0, 0));
    chk("dump_data", r, 32'h5555_1004);
    tx(cw(CMD_WRITE, 0, SIZE_WORD, 0));
    tx(32'h0000_2000);
    tx(32'h0000_beef);
    chk("wr_addr", a_adr, 32'h0000_2000);
    chk("wr_fc", a_fc, 3'h2);
    chk("wr_size", a_sz, SIZE_WORD);
    chk("wr_mdata", a_wd, 32'h0000_beef);
    chk("wr_we", a_we, 1);
    tx(cw(CMD_FILL, 0, SIZE_WORD, 0));
    tx(32'h0000_1234);
    chk("fill_addr", a_adr, 32'h0000_2002);
    chk("fill_data", a_wd, 32'h0000_1234);
  endtask : t_mem

  task automatic t_ctl();
    b0 = n_prst;
    tx(cw(CMD_RST, 0, 0, 0));
    repeat (600) @(posedge clock_i);
    chk("prst_len", n_prst - b0, RST_CYCLES);
    chk("prst_core", background_debug_mode_o, 1);
    b0 = n_pcl;
    b1 = n_push;
    b2 = n_flush;
    tx(cw(CMD_CALL, 0, 0, 0));
    tx(32'h0000_6000);
    chk("call_addr", a_adr, 32'h0000_7ffc);
    chk("call_data", a_wd, 32'h0000_4000);
    chk("call_fc", a_fc, FC_SUP_DATA);
    chk("call_we", a_we, 1);
    chk("call_pcl", n_pcl - b0, 1);
    chk("call_push", n_push - b1, 1);
    chk("call_pc", pc_value_o, 32'h0000_6000);
    chk("call_dbg_mode", background_debug_mode_o, 0);
    chk("call_flush", n_flush - b2, 1);
    exc(16'h4e71, 0, 0, 2'h0, 1, 8'h00);
    b2 = n_flush;
    tx(cw(CMD_GO, 0, 0, 0));
    chk("go_flush", n_flush - b2, 1);
    chk("go_dbg_mode", background_debug_mode_o, 0);
    b0 = n_wr;
    tx(cw(CMD_WRGEN, 0, SIZE_LONG, 4'h1));
    tx(32'h0000_0077);
    chk("run_ignored", n_wr, b0);
  endtask : t_ctl

  // ****************
  // main sequence
  // ****************
  initial begin
    resetn_i = 1'b0;
    mem_ack_i = 1'b0;
    instr_done_i = 1'b0;
    illegal_i = 1'b0;
    flow_change_i = 1'b0;
    bkpt_ack_i = 1'b0;
    bkpt_to_debug_i = 1'b0;
    trace_mode_i = 2'h0;
    opcode_i = 16'h0000;
    source_space_code_reg_i = 3'h1;
    destination_space_code_reg_i = 3'h2;
    pc_i = 32'h0000_4000;
    stack_ptr_i = 32'h0000_8000;
    repeat (10) @(posedge clock_i);
    #1 resetn_i = 1'b1;
    chk("rst_dbg_mode", background_debug_mode_o, 0);
    chk("rst_size", mem_size_o, SIZE_LONG);
    chk("rst_fc", mem_fc_o, FC_SUP_DATA);
    chk("rst_prst", periph_reset_o, 0);
    t_exc();
    t_regs();
    t_mem();
    t_ctl();
    test_done();
  end
endmodule : test_background_debug_command_unit
